// file: fcad_consts.svh
// Constants for the flash command host: addresses, codes, bits, timing.
// Assumes a 40 MHz clock; included by the package, the host and the bus cycle engine.
// Operation
// [R1] In identification mode the flash returns maker, part or protect code.
// [R2] Pin identification: high voltage on bit nine, bit six low, read.
// [R3] Identification is also entered by command, without high voltage.
// [R4] Protect query puts the sector number on the top address bits.
// [R5] Protect status reads 01H when protected, 00H when not.
// [R6] One write of F0H anywhere returns the flash to array read.
// [R7] Every multi-write command opens with AAH@555H then 55H@2AAH.
// [R8] Unlock then 90H@555H enters identification; offsets 00, 01, 02.
// [R9] Program: unlock pair, A0H@555H, then target address and byte.
// [R10] Chip erase: unlock, 80H@555H, unlock again, 10H@555H.
// [R11] Sector erase: as chip erase, last write 30H at the sector.
// [R12] B0H suspends, 30H resumes, only while a sector erase runs; the host allows both from sector erase start until a reset.
// [R13] A mismatching write discards the sequence and returns to read.
// [R14] Chip select and output gate low, strobe high: flash drives data.
// [R15] Write: chip select low, output gate high, strobe low, host drives.
// [R16] Chip select low, gate and strobe high: data lines float.
// [R17] Chip select high: data lines float whatever else is set.
// [R18] Protect write: bits six, one, zero = 0,1,0; bit six high unprotects.
// [R19] Address taken at strobe fall, data at strobe rise.
// [R20] Programming ignores commands; sector erase accepts only suspend.
// [R21] Reset must be issued to leave identification mode.
// [R22] Only the low eleven address bits matter in command writes.
`ifndef FCAD_CONSTS_SVH
`define FCAD_CONSTS_SVH

`define FCAD_ADDR_W 19
`define FCAD_ADDR_UNLOCK1 19'h00555
`define FCAD_ADDR_UNLOCK2 19'h002AA
`define FCAD_CODE_UNLOCK1 8'hAA
`define FCAD_CODE_UNLOCK2 8'h55
`define FCAD_CODE_RESET 8'hF0
`define FCAD_CODE_AUTOSEL 8'h90
`define FCAD_CODE_PROGRAM 8'hA0
`define FCAD_CODE_ERASE_SETUP 8'h80
`define FCAD_CODE_CHIP_ERASE 8'h10
`define FCAD_CODE_SECT_ERASE 8'h30
`define FCAD_CODE_SUSPEND 8'hB0
`define FCAD_CODE_RESUME 8'h30
`define FCAD_BIT_SEL6 6
`define FCAD_BIT_SEL1 1
`define FCAD_SECT_LSB 16

// Bus timing in ns and derived cycle counts (least times round up)
`define FCAD_CLK_NS 25
`define FCAD_T_SETUP_NS 25
`define FCAD_T_WP_NS 35
`define FCAD_T_ACC_NS 70
`define FCAD_T_REC_NS 20
`define FCAD_CYC(ns) (((ns) + `FCAD_CLK_NS - 1) / `FCAD_CLK_NS)
`define FCAD_SETUP_CYC `FCAD_CYC(`FCAD_T_SETUP_NS)
`define FCAD_WP_CYC `FCAD_CYC(`FCAD_T_WP_NS)
`define FCAD_ACC_CYC `FCAD_CYC(`FCAD_T_ACC_NS)
`define FCAD_REC_CYC `FCAD_CYC(`FCAD_T_REC_NS)

`endif

// file: fcad_pkg.sv
// Types shared by the flash command host and its bus cycle engine.
// Assumes fcad_consts.svh is on the include path.
`include "fcad_consts.svh"
package fcad_pkg;
   typedef enum logic [3:0] {
      FCAD_OP_READ = 4'h0,
      FCAD_OP_RESET = 4'h1,
      FCAD_OP_PROGRAM = 4'h2,
      FCAD_OP_CHIP_ERASE = 4'h3,
      FCAD_OP_SECT_ERASE = 4'h4,
      FCAD_OP_SUSPEND = 4'h5,
      FCAD_OP_RESUME = 4'h6,
      FCAD_OP_ID_READ = 4'h7,
      FCAD_OP_HV_ID_READ = 4'h8,
      FCAD_OP_SECT_PROTECT = 4'h9,
      FCAD_OP_CHIP_UNPROTECT = 4'hA
   } fcad_op_e;

   typedef enum logic [1:0] {
      FCAD_BUS_IDLE = 2'h0,
      FCAD_BUS_SETUP = 2'h1,
      FCAD_BUS_STROBE = 2'h3,
      FCAD_BUS_RELEASE = 2'h2
   } fcad_bus_e;

   typedef enum logic [1:0] {
      FCAD_SEQ_IDLE = 2'h0,
      FCAD_SEQ_ISSUE = 2'h1,
      FCAD_SEQ_WAIT = 2'h3
   } fcad_seq_e;

   // Pins driven toward the flash
   typedef struct packed {
      logic ceN;
      logic oeN;
      logic weN;
      logic [`FCAD_ADDR_W-1:0] addr;
      logic [7:0] dq;
      logic dqOe;
      logic hvId;
   } fcad_pins_s;

   // One bus cycle of a command sequence
   typedef struct packed {
      logic isWrite;
      logic hvId;
      logic [`FCAD_ADDR_W-1:0] addr;
      logic [7:0] data;
      logic last;
   } fcad_step_s;
endpackage : fcad_pkg

// file: fcad_bus_cycle.sv
// Bus cycle engine: runs one read or write cycle on the flash pins.
// Assumes start is a one-cycle pulse given only while idle.
`include "fcad_consts.svh"
module fcad_bus_cycle
   import fcad_pkg::*;
(
   input wire logic clk,
   input wire logic rstN,
   input wire logic start,
   input wire fcad_step_s step,
   input wire logic [7:0] dqIn,
   output fcad_pins_s pins,
   output logic done,
   output logic [7:0] rdata
);
   fcad_bus_e state, next_state;
   logic [2:0] cnt, next_cnt;
   logic isWr, next_isWr;
   fcad_pins_s next_pins;
   logic next_done;
   logic [7:0] next_rdata;

   // Cycle phases: setup, strobe, release with held data
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_isWr = isWr;
      next_pins = pins;
      next_done = 1'b0;
      next_rdata = rdata;
      unique case (state)
         FCAD_BUS_IDLE: begin
            if (start) begin
               next_isWr = step.isWrite;
               next_pins.addr = step.addr;
               next_pins.dq = step.data;
               next_pins.dqOe = step.isWrite; // R15
               next_pins.hvId = step.hvId;
               next_pins.ceN = 1'b0;
               next_cnt = 3'(`FCAD_SETUP_CYC - 1);
               next_state = FCAD_BUS_SETUP;
            end
         end
         FCAD_BUS_SETUP: begin
            if (cnt == 3'h0) begin
               // Address settled before the strobe falls
               if (isWr) begin
                  next_pins.weN = 1'b0; // R19
                  next_cnt = 3'(`FCAD_WP_CYC - 1);
               end else begin
                  next_pins.oeN = 1'b0; // R14
                  next_cnt = 3'(`FCAD_ACC_CYC - 1);
               end
               next_state = FCAD_BUS_STROBE;
            end else begin
               next_cnt = cnt - 3'h1;
            end
         end
         FCAD_BUS_STROBE: begin
            if (cnt == 3'h0) begin
               if (!isWr) begin
                  next_rdata = dqIn;
               end
               next_pins.weN = 1'b1;
               next_pins.oeN = 1'b1;
               next_cnt = 3'(`FCAD_REC_CYC - 1);
               next_state = FCAD_BUS_RELEASE;
            end else begin
               next_cnt = cnt - 3'h1;
            end
         end
         FCAD_BUS_RELEASE: begin
            if (cnt == 3'h0) begin
               // Data held past the strobe rise, then released
               next_pins.ceN = 1'b1; // R19
               next_pins.dqOe = 1'b0;
               next_pins.hvId = 1'b0;
               next_done = 1'b1;
               next_state = FCAD_BUS_IDLE;
            end else begin
               next_cnt = cnt - 3'h1;
            end
         end
      endcase
   end

   // State registers
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state <= FCAD_BUS_IDLE;
         cnt <= 3'h0;
         isWr <= 1'b0;
         pins <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, default: '0};
         done <= 1'b0;
         rdata <= 8'h00;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         isWr <= next_isWr;
         pins <= next_pins;
         done <= next_done;
         rdata <= next_rdata;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstN);

   strobe_exclusive_a: assert property (!(!pins.oeN && !pins.weN)) // R15
      else $error("output gate and write strobe low together");
   ce_guard_a: assert property ((!pins.oeN || !pins.weN) |-> !pins.ceN) // R14
      else $error("strobe without chip select");
   no_fight_a: assert property (pins.dqOe |-> pins.oeN) // R15
      else $error("host drives data during a read");
   we_width_a: assert property ($fell(pins.weN) |-> ##1 !pins.weN ##1 pins.weN) // R19
      else $error("write pulse not two cycles");
   addr_stable_a: assert property (!pins.weN |-> $stable(pins.addr)) // R19
      else $error("address moved under the write strobe");
   data_hold_a: assert property ($rose(pins.weN) |-> pins.dqOe && !pins.ceN) // R19
      else $error("data dropped at strobe rise");
   hv_read_a: assert property (pins.hvId |-> pins.weN && !pins.addr[6]) // R2
      else $error("high voltage id outside a bit-six-low read");
endmodule : fcad_bus_cycle

// file: fcad_host.sv
// Flash command host: turns one user command into flash bus cycles.
// Assumes the flash pins are wired through an external id voltage switch.
`include "fcad_consts.svh"
module fcad_host
   import fcad_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic cmdValid,
   input wire fcad_op_e cmdOp,
   input wire logic [`FCAD_ADDR_W-1:0] cmdAddr,
   input wire logic [7:0] cmdData,
   output logic cmdReady,
   output logic respValid,
   output logic respRefused,
   output logic [7:0] respData,
   output fcad_pins_s flash,
   input wire logic [7:0] flashDqIn
);
   logic [1:0] rstSync;
   logic rstN;
   fcad_seq_e state, next_state;
   fcad_op_e op, next_op;
   logic [`FCAD_ADDR_W-1:0] addr, next_addr;
   logic [7:0] data, next_data;
   logic [2:0] idx, next_idx;
   logic eraseActive, next_eraseActive;
   logic next_cmdReady, next_respValid, next_respRefused;
   logic [7:0] next_respData;
   fcad_step_s step;
   logic busDone;
   logic [7:0] busRdata;

   // Reset released through two flip-flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstN = rstSync[1];

   // Bus cycle for step i of a command
   function automatic fcad_step_s stepOf(fcad_op_e o, logic [2:0] i,
         logic [`FCAD_ADDR_W-1:0] a, logic [7:0] d);
      fcad_step_s s;
      logic [`FCAD_ADDR_W-1:0] sect;
      s = '{isWrite: 1'b1, default: '0};
      sect = '0;
      sect[`FCAD_ADDR_W-1:`FCAD_SECT_LSB] = a[`FCAD_ADDR_W-1:`FCAD_SECT_LSB];
      // Unlock pair opens every multi-write command
      if (i == 3'h0 || i == 3'h3) begin
         s.addr = `FCAD_ADDR_UNLOCK1; // R7 R22
         s.data = `FCAD_CODE_UNLOCK1;
      end else begin
         s.addr = `FCAD_ADDR_UNLOCK2; // R7 R22
         s.data = `FCAD_CODE_UNLOCK2;
      end
      unique case (o)
         FCAD_OP_READ: begin
            s.isWrite = 1'b0;
            s.addr = a;
            s.last = 1'b1;
         end
         FCAD_OP_RESET: begin
            s.addr = '0;
            s.data = `FCAD_CODE_RESET; // R6
            s.last = 1'b1;
         end
         FCAD_OP_PROGRAM: begin
            if (i == 3'h2) begin
               s.addr = `FCAD_ADDR_UNLOCK1;
               s.data = `FCAD_CODE_PROGRAM; // R9
            end else if (i == 3'h3) begin
               s.addr = a;
               s.data = d;
               s.last = 1'b1;
            end
         end
         FCAD_OP_CHIP_ERASE, FCAD_OP_SECT_ERASE: begin
            if (i == 3'h2) begin
               s.addr = `FCAD_ADDR_UNLOCK1;
               s.data = `FCAD_CODE_ERASE_SETUP; // R10 R11
            end else if (i == 3'h5) begin
               s.last = 1'b1;
               if (o == FCAD_OP_CHIP_ERASE) begin
                  s.addr = `FCAD_ADDR_UNLOCK1;
                  s.data = `FCAD_CODE_CHIP_ERASE; // R10
               end else begin
                  s.addr = sect;
                  s.data = `FCAD_CODE_SECT_ERASE; // R11
               end
            end
         end
         FCAD_OP_SUSPEND, FCAD_OP_RESUME: begin
            s.addr = '0;
            s.data = (o == FCAD_OP_SUSPEND) ? `FCAD_CODE_SUSPEND
                                             : `FCAD_CODE_RESUME; // R12
            s.last = 1'b1;
         end
         FCAD_OP_ID_READ: begin
            if (i == 3'h2) begin
               s.addr = `FCAD_ADDR_UNLOCK1;
               s.data = `FCAD_CODE_AUTOSEL; // R3 R8
            end else if (i == 3'h3) begin
               s.isWrite = 1'b0;
               s.addr = sect; // R4
               s.addr[1:0] = a[1:0]; // R8
            end else if (i == 3'h4) begin
               s.addr = '0;
               s.data = `FCAD_CODE_RESET; // R21
               s.last = 1'b1;
            end
         end
         FCAD_OP_HV_ID_READ: begin
            s.isWrite = 1'b0;
            s.hvId = 1'b1; // R2
            s.addr = sect;
            s.addr[1:0] = a[1:0];
            s.last = 1'b1;
         end
         FCAD_OP_SECT_PROTECT, FCAD_OP_CHIP_UNPROTECT: begin
            s.addr = (o == FCAD_OP_SECT_PROTECT) ? sect : '0;
            s.addr[`FCAD_BIT_SEL6] = (o == FCAD_OP_CHIP_UNPROTECT); // R18
            s.addr[`FCAD_BIT_SEL1] = 1'b1;
            s.data = 8'h00;
            s.last = 1'b1;
         end
         default: begin
            s.last = 1'b1;
         end
      endcase
      return s;
   endfunction : stepOf

   assign step = stepOf(op, idx, addr, data);

   fcad_bus_cycle u_bus (
      .clk(clk),
      .rstN(rstN),
      .start(state == FCAD_SEQ_ISSUE),
      .step(step),
      .dqIn(flashDqIn),
      .pins(flash),
      .done(busDone),
      .rdata(busRdata)
   );

   // Command sequencer
   always_comb begin
      next_state = state;
      next_op = op;
      next_addr = addr;
      next_data = data;
      next_idx = idx;
      next_eraseActive = eraseActive;
      next_cmdReady = cmdReady;
      next_respValid = 1'b0;
      next_respRefused = 1'b0;
      next_respData = respData;
      unique case (state)
         FCAD_SEQ_IDLE: begin
            next_cmdReady = 1'b1; // Idle always offers a slot
            if (cmdValid && cmdReady) begin
               if ((cmdOp == FCAD_OP_SUSPEND || cmdOp == FCAD_OP_RESUME)
                     && !eraseActive) begin
                  next_respRefused = 1'b1; // R12
               end else begin
                  next_op = cmdOp;
                  next_addr = cmdAddr;
                  next_data = cmdData;
                  next_idx = 3'h0;
                  next_cmdReady = 1'b0;
                  next_state = FCAD_SEQ_ISSUE;
               end
            end
         end
         FCAD_SEQ_ISSUE: begin
            next_state = FCAD_SEQ_WAIT;
         end
         FCAD_SEQ_WAIT: begin
            if (busDone) begin
               if (!step.isWrite) begin
                  next_respData = busRdata;
               end
               if (step.last) begin
                  if (op == FCAD_OP_SECT_ERASE) begin
                     next_eraseActive = 1'b1;
                  end else if (op == FCAD_OP_RESET) begin
                     next_eraseActive = 1'b0; // R6
                  end
                  next_respValid = 1'b1;
                  next_cmdReady = 1'b1;
                  next_state = FCAD_SEQ_IDLE;
               end else begin
                  next_idx = idx + 3'h1;
                  next_state = FCAD_SEQ_ISSUE;
               end
            end
         end
         default: begin
            next_state = FCAD_SEQ_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state <= FCAD_SEQ_IDLE;
         op <= FCAD_OP_READ;
         addr <= '0;
         data <= 8'h00;
         idx <= 3'h0;
         eraseActive <= 1'b0;
         cmdReady <= 1'b0;
         respValid <= 1'b0;
         respRefused <= 1'b0;
         respData <= 8'h00;
      end else begin
         state <= next_state;
         op <= next_op;
         addr <= next_addr;
         data <= next_data;
         idx <= next_idx;
         eraseActive <= next_eraseActive;
         cmdReady <= next_cmdReady;
         respValid <= next_respValid;
         respRefused <= next_respRefused;
         respData <= next_respData;
      end
   end

   // Write tracking for the checks below
   logic [2:0] wrCnt;
   logic [7:0] firstWr, lastWr;
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wrCnt <= 3'h0;
         firstWr <= 8'h00;
         lastWr <= 8'h00;
      end else if (cmdValid && cmdReady) begin
         wrCnt <= 3'h0;
      end else if ($fell(flash.weN)) begin
         wrCnt <= wrCnt + 3'h1;
         lastWr <= flash.dq;
         if (wrCnt == 3'h0) begin
            firstWr <= flash.dq;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstN);

   program_count_a: assert property (respValid && op == FCAD_OP_PROGRAM
         |-> wrCnt == 3'h4) // R9
      else $error("program did not take four writes");
   erase_count_a: assert property (respValid && (op == FCAD_OP_CHIP_ERASE
         || op == FCAD_OP_SECT_ERASE) |-> wrCnt == 3'h6) // R10
      else $error("erase did not take six writes");
   unlock_first_a: assert property (respValid && (op == FCAD_OP_PROGRAM
         || op == FCAD_OP_ID_READ) |-> firstWr == 8'hAA) // R7
      else $error("command did not open with the unlock code");
   id_exit_a: assert property (respValid && op == FCAD_OP_ID_READ
         |-> lastWr == 8'hF0 && wrCnt == 3'h4) // R21
      else $error("identification left without reset");
   reset_single_a: assert property (respValid && op == FCAD_OP_RESET
         |-> wrCnt == 3'h1 && lastWr == 8'hF0) // R6
      else $error("reset not a single F0 write");
   protect_addr_a: assert property ($fell(flash.weN)
         && op == FCAD_OP_SECT_PROTECT
         |-> flash.addr[1:0] == 2'b10 && !flash.addr[6]) // R18
      else $error("protect write with wrong select bits");
   id_offset_a: assert property ($fell(flash.oeN) && op == FCAD_OP_ID_READ
         |-> flash.addr[15:2] == 14'h0) // R8
      else $error("identification read off its offset");
   hv_only_a: assert property (flash.hvId |-> op == FCAD_OP_HV_ID_READ) // R3
      else $error("high voltage used outside pin identification");
   refuse_a: assert property (cmdValid && cmdReady && !eraseActive
         && cmdOp == FCAD_OP_SUSPEND |=> respRefused && cmdReady) // R12
      else $error("suspend taken with no erase running");
   upper_zero_a: assert property ($fell(flash.weN) && op == FCAD_OP_CHIP_ERASE
         |-> flash.addr[18:11] == 8'h00) // R22
      else $error("command write with upper address bits set");

   program_c: cover property (respValid && op == FCAD_OP_PROGRAM);
   id_read_c: cover property (respValid && op == FCAD_OP_ID_READ);
   sect_erase_c: cover property (respValid && op == FCAD_OP_SECT_ERASE);
   hv_read_c: cover property (respValid && op == FCAD_OP_HV_ID_READ);
   refused_c: cover property (respRefused);
endmodule : fcad_host

// file: fcad_flash_model.sv
// Behavioural flash device facing the command host pins.
// Assumes the host holds address and data through each write strobe.
module fcad_flash_model
   import fcad_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'h5E, // Arbitrary value
   parameter logic [7:0] PART_CODE = 8'h3C, // Arbitrary value
   parameter int ERASE_NS = 2000
)
(
   input wire fcad_pins_s flash,
   output logic [7:0] dqOut
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [logic [18:0]];
   logic [7:0] prot = 8'h00;
   logic [2:0] step = 3'h0;
   logic idMode = 1'b0;
   logic busy = 1'b0;
   logic suspended = 1'b0;
   logic [2:0] erasedSector = 3'h0;
   logic [7:0] rdVal;
   logic [10:0] a;
   logic [7:0] d;
   event restart;

   // Command decode; address and data taken at the strobe rise
   always @(posedge flash.weN) begin
      a = flash.addr[10:0];
      d = flash.dq;
      if (flash.ceN) begin
      end else if (busy) begin
         if (d == 8'hB0 && !suspended) suspended = 1'b1;
         else if (d == 8'h30 && suspended) begin
            suspended = 1'b0;
            ->restart;
         end
      end else if (d == 8'hF0) begin
         step = 3'h0;
         idMode = 1'b0;
      end else begin
         case (step)
            3'h0, 3'h4: begin
               if (a == 11'h555 && d == 8'hAA) step = step + 3'h1;
               else if (step == 3'h0 && d == 8'h00 && a[1:0] == 2'h2) begin
                  if (!a[6]) prot[flash.addr[18:16]] = 1'b1;
                  else prot = 8'h00;
               end else step = 3'h0;
            end
            3'h1, 3'h5: begin
               if (a == 11'h2AA && d == 8'h55) step = step + 3'h1;
               else step = 3'h0;
            end
            3'h2: begin
               step = 3'h0;
               if (a == 11'h555 && d == 8'h90) idMode = 1'b1;
               else if (a == 11'h555 && d == 8'hA0) step = 3'h3;
               else if (a == 11'h555 && d == 8'h80) step = 3'h4;
               else idMode = 1'b0;
            end
            3'h3: begin
               mem[flash.addr] = d;
               step = 3'h0;
            end
            default: begin
               step = 3'h0;
               if (a == 11'h555 && d == 8'h10) mem.delete();
               else if (d == 8'h30) begin
                  erasedSector = flash.addr[18:16];
                  busy = 1'b1;
                  ->restart;
               end
            end
         endcase
      end
   end

   // Erase run time, runs on while suspended; busy kept if still suspended at its end
   always begin
      @(restart);
      #ERASE_NS;
      if (!suspended) busy = 1'b0;
   end

   // Read value: identifier codes or array data
   always @* begin
      if (idMode || (flash.hvId && !flash.addr[6])) begin
         case (flash.addr[1:0])
            2'h0: rdVal = MAKER_CODE;
            2'h1: rdVal = PART_CODE;
            default: rdVal = {7'h00, prot[flash.addr[18:16]]};
         endcase
      end else if (mem.exists(flash.addr)) rdVal = mem[flash.addr];
      else rdVal = 8'hFF;
   end

   // Released lines show the inverse, never a held value
   assign dqOut = (!flash.ceN && !flash.oeN && flash.weN) ? rdVal : ~rdVal;
endmodule : fcad_flash_model

// file: flash_command_autoselect_decoder_tb_top.sv
// Self-checking bench for the flash command host with a flash model.
// Assumes the host answers every command within 400 clock cycles, ready wait included.
module flash_command_autoselect_decoder_tb_top
   import fcad_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MAKER = 8'h5E; // Arbitrary value
   localparam logic [7:0] PART = 8'h3C; // Arbitrary value
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cmdValid = 1'b0;
   fcad_op_e cmdOp = FCAD_OP_READ;
   logic [18:0] cmdAddr = 19'h00000;
   logic [7:0] cmdData = 8'h00;
   logic cmdReady, respValid, respRefused;
   logic [7:0] respData, modelDq, dqWire, rdata;
   logic refused;
   fcad_pins_s flash;
   int fails = 0;
   int totalChecks = 0;
   int pinBad = 0;

   always #12.5 clk = ~clk;

   fcad_host uut (.clk(clk), .nrst(nrst), .cmdValid(cmdValid),
      .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
      .cmdReady(cmdReady), .respValid(respValid),
      .respRefused(respRefused), .respData(respData), .flash(flash),
      .flashDqIn(dqWire));
   fcad_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART),
      .ERASE_NS(2000)) flashModel (.flash(flash), .dqOut(modelDq));

   // Shared data wire, chosen by the host's dqOe enable alone
   assign dqWire = flash.dqOe ? flash.dq : modelDq;

   // Strobe overlap and contention watch, sampled on settled pins
   always @(negedge clk) begin
      if (!flash.oeN && (!flash.weN || flash.ceN || flash.dqOe)) pinBad++;
      if (!flash.weN && (flash.ceN || !flash.dqOe)) pinBad++;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp,
      input string what);
      totalChecks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what,
            got, exp);
      end
   endtask : check

   // One command handshake, waits for its answer
   task automatic doCmd(input fcad_op_e op, input logic [18:0] addr,
      input logic [7:0] data);
      int n;
      n = 0;
      while (cmdReady !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      cmdOp = op;
      cmdAddr = addr;
      cmdData = data;
      cmdValid = 1'b1;
      @(negedge clk);
      cmdValid = 1'b0;
      while (respValid !== 1'b1 && respRefused !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      refused = respRefused;
      rdata = respData;
      check({7'h00, n >= 400}, 8'h00, "no answer");
      @(negedge clk);
   endtask : doCmd

   task automatic t_program_read();
      doCmd(FCAD_OP_PROGRAM, 19'h12345, 8'h5A);
      doCmd(FCAD_OP_READ, 19'h12345, 8'h00);
      check(rdata, 8'h5A, "read back");
      doCmd(FCAD_OP_READ, 19'h12346, 8'h00);
      check(rdata, 8'hFF, "blank read");
   endtask : t_program_read

   task automatic t_id();
      doCmd(FCAD_OP_ID_READ, 19'h30000, 8'h00);
      check(rdata, MAKER, "maker code");
      doCmd(FCAD_OP_ID_READ, 19'h30001, 8'h00);
      check(rdata, PART, "part code");
      doCmd(FCAD_OP_ID_READ, 19'h30002, 8'h00);
      check(rdata, 8'h00, "unprotected");
      check({7'h00, flashModel.idMode}, 8'h00, "id mode left");
      doCmd(FCAD_OP_READ, 19'h12345, 8'h00);
      check(rdata, 8'h5A, "array after id");
   endtask : t_id

   task automatic t_protect();
      doCmd(FCAD_OP_SECT_PROTECT, 19'h50000, 8'h00);
      doCmd(FCAD_OP_HV_ID_READ, 19'h50002, 8'h00);
      check(rdata, 8'h01, "protected");
      doCmd(FCAD_OP_HV_ID_READ, 19'h40002, 8'h00);
      check(rdata, 8'h00, "other sector");
      doCmd(FCAD_OP_HV_ID_READ, 19'h00000, 8'h00);
      check(rdata, MAKER, "pin maker code");
      doCmd(FCAD_OP_ID_READ, 19'h50002, 8'h00);
      check(rdata, 8'h01, "command protect read");
      doCmd(FCAD_OP_CHIP_UNPROTECT, 19'h00000, 8'h00);
      doCmd(FCAD_OP_HV_ID_READ, 19'h50002, 8'h00);
      check(rdata, 8'h00, "unprotected chip");
   endtask : t_protect

   task automatic t_erase();
      int n;
      doCmd(FCAD_OP_SUSPEND, 19'h00000, 8'h00);
      check({7'h00, refused}, 8'h01, "idle suspend");
      doCmd(FCAD_OP_CHIP_ERASE, 19'h00000, 8'h00);
      doCmd(FCAD_OP_READ, 19'h12345, 8'h00);
      check(rdata, 8'hFF, "chip erased");
      doCmd(FCAD_OP_SECT_ERASE, 19'h20000, 8'h00);
      check({5'h00, flashModel.erasedSector}, 8'h02, "sector");
      doCmd(FCAD_OP_PROGRAM, 19'h60010, 8'h11);
      doCmd(FCAD_OP_SUSPEND, 19'h00000, 8'h00);
      check({7'h00, refused}, 8'h00, "suspend taken");
      check({7'h00, flashModel.suspended}, 8'h01, "suspended");
      doCmd(FCAD_OP_RESUME, 19'h00000, 8'h00);
      check({7'h00, flashModel.suspended}, 8'h00, "resumed");
      n = 0;
      while (flashModel.busy && n < 200) begin
         @(negedge clk);
         n++;
      end
      doCmd(FCAD_OP_READ, 19'h60010, 8'h00);
      check(rdata, 8'hFF, "program ignored");
      doCmd(FCAD_OP_RESET, 19'h00000, 8'h00);
      doCmd(FCAD_OP_RESUME, 19'h00000, 8'h00);
      check({7'h00, refused}, 8'h01, "resume after reset");
   endtask : t_erase

   task automatic summarize();
      $display("checks %0d mismatches %0d", totalChecks, fails);
      if (fails == 0 && totalChecks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   // Watchdog well past the expected run
   initial begin
      #500000;
      fails++;
      $display("mismatch at %0t: watchdog expired", $time);
      summarize();
   end

   // Main sequence
   initial begin
      repeat (8) @(negedge clk);
      check({7'h00, cmdReady}, 8'h00, "ready in reset");
      check({7'h00, flash.ceN}, 8'h01, "deselected in reset");
      nrst = 1'b1;
      t_program_read();
      t_id();
      t_protect();
      t_erase();
      check({7'h00, pinBad != 0}, 8'h00, "pin discipline");
      summarize();
   end
endmodule : flash_command_autoselect_decoder_tb_top
